// ==== core/afp_pkg.sv ====
package afp_pkg;
   localparam int CLK_NS = 100;
   localparam int SYNC_STAGES = 2;
   // Strobe timing of the fastest memory grade
   localparam int T_RAS_MIN_NS = 25;
   localparam int T_RAS_MAX_NS = 10000;
   localparam int T_RP_NS = 15;
   localparam int T_RAC_NS = 25;
   // Least times round up, longest round down, never under one cycle
   localparam int RAS_MIN_CYC = ((T_RAS_MIN_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 :
                                (T_RAS_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int RAS_MAX_CYC = (T_RAS_MAX_NS / CLK_NS < 1) ? 1 : T_RAS_MAX_NS / CLK_NS;
   localparam int RP_CYC = ((T_RP_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 : (T_RP_NS + CLK_NS - 1) / CLK_NS;
   localparam int RAC_CYC = ((T_RAC_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 : (T_RAC_NS + CLK_NS - 1) / CLK_NS;
   localparam int RD_HOLD_CYC = SYNC_STAGES + RAC_CYC - 1;
   localparam int PAGE_GUARD_CYC = 8;
   // Power-up and refresh duties
   localparam int T_PWR_US = 200;
   localparam int PWR_CYC = T_PWR_US * 1000 / CLK_NS;
   localparam int REF_PERIOD_MS = 4;
   localparam int REF_ROWS = 256;
   localparam int REF_INT_CYC = REF_PERIOD_MS * 1000000 / CLK_NS / REF_ROWS;
   localparam int WAKE_CYCLES = 8;
   localparam int REF_OVERDUE = 256;
   localparam int TMR_W = 4;
   localparam int ADDR_HALF = 8;
   typedef enum logic [10:0] {
      S_PWR  = 11'h001,
      S_IDLE = 11'h002,
      S_ROW  = 11'h004,
      S_COL  = 11'h008,
      S_PAGE = 11'h010,
      S_PRE  = 11'h020,
      S_CBRC = 11'h040,
      S_CBRR = 11'h080,
      S_HIDH = 11'h100,
      S_HIDL = 11'h200,
      S_DONE = 11'h400
   } afp_state_type;
endpackage

// ==== core/afp_ctl_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface afp_ctl_if;
   import afp_pkg::*;
   logic tmr_load;
   logic [TMR_W-1:0] tmr_val;
   logic tmr_zero;
   logic ref_ack;
   logic ref_due;
   logic pwr_done;
   logic [8:0] ref_pending;
   modport timer (input tmr_load, input tmr_val, output tmr_zero);
   modport refresh (input ref_ack, output ref_due, output pwr_done, output ref_pending);
   modport fsm (output tmr_load, output tmr_val, input tmr_zero, output ref_ack,
                input ref_due, input pwr_done, input ref_pending);
endinterface
`default_nettype wire

// ==== core/afp_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
module afp_timer
   import afp_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   afp_ctl_if.timer t
);
   logic [TMR_W-1:0] cnt_reg;

   // Down counter, reload wins over counting
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_reg <= '0;
      end else if (t.tmr_load) begin
         cnt_reg <= t.tmr_val;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   assign t.tmr_zero = (cnt_reg == '0);
endmodule
`default_nettype wire

// ==== core/afp_refresh.sv ====
`timescale 1ns/1ns
`default_nettype none
module afp_refresh
   import afp_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   afp_ctl_if.refresh r
);
   logic [10:0] pwr_cnt_reg;
   logic pwr_done_reg;
   logic [7:0] tick_cnt_reg;
   logic tick;
   logic [8:0] pending_reg;
   logic [3:0] wake_reg;

   // Power-up pause before any strobe activity
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pwr_cnt_reg <= '0;
         pwr_done_reg <= 1'b0;
      end else if (!pwr_done_reg) begin
         pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
         pwr_done_reg <= (pwr_cnt_reg == 11'(PWR_CYC - 1));
      end
   end

   // One refresh owed every interval slice
   always_ff @(posedge clk) begin
      if (!resetn || !pwr_done_reg) begin
         tick_cnt_reg <= '0;
      end else if (tick) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 1'b1;
      end
   end
   assign tick = (tick_cnt_reg == 8'(REF_INT_CYC - 1));

   // Owed count; after wake-up, a new slice and a finished refresh in one cycle cancel out
   always_ff @(posedge clk) begin
      if (!resetn || !pwr_done_reg) begin
         pending_reg <= '0;
         wake_reg <= 4'(WAKE_CYCLES);
      end else if (pending_reg == 9'(REF_OVERDUE)) begin
         pending_reg <= '0;
         wake_reg <= 4'(WAKE_CYCLES);
      end else if (r.ref_ack && wake_reg != '0) begin
         wake_reg <= wake_reg - 1'b1;
         pending_reg <= pending_reg + {8'h00, tick};
      end else if (r.ref_ack && !tick && pending_reg != '0) begin
         pending_reg <= pending_reg - 1'b1;
      end else if (tick && !r.ref_ack) begin
         pending_reg <= pending_reg + 1'b1;
      end
   end

   assign r.pwr_done = pwr_done_reg;
   assign r.ref_due = pwr_done_reg && (pending_reg != '0 || wake_reg != '0);
   assign r.ref_pending = pending_reg;

   property p_ref_bound;
      @(posedge clk) disable iff (!resetn) pending_reg <= 9'(REF_OVERDUE);
   endproperty
   a_ref_bound: assert property (p_ref_bound) else $error("refresh debt over limit");

   property p_wake_reload;
      @(posedge clk) disable iff (!resetn)
         (pwr_done_reg && pending_reg == 9'(REF_OVERDUE)) |=> (wake_reg == 4'(WAKE_CYCLES));
   endproperty
   a_wake_reload: assert property (p_wake_reload) else $error("wake-up not rearmed");
endmodule
`default_nettype wire

// ==== core/afp_dram_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Row half on row strobe, column half after
// - Cycle opens on row fall, ends all high
// - Row strobe held low minimum active time
// - Precharge time observed before next cycle
// - Read: column strobe/drive enable, write select high
// - Column address held stable during read
// - Write starts at later column/write fall
// - Write data valid by that falling edge
// - Page mode: columns cycled, row held
// - 256 refreshes within every 4 ms
// - Counter refresh: row falls, column low
// - Counter refresh needs one lane strobe
// - 200 us pause, eight wake cycles
// - Repeat wake-up after missed refresh
module afp_dram_ctrl
   import afp_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [15:0] req_addr,
   input wire logic [1:0] req_lanes,
   input wire logic [15:0] req_wdata,
   output logic rsp_valid,
   output logic [15:0] rsp_rdata,
   output logic row_strobe_n,
   output logic low_lane_col_strobe_n,
   output logic high_lane_col_strobe_n,
   output logic write_sel_n,
   output logic out_drive_n,
   output logic [7:0] mux_addr_pins,
   input wire logic [15:0] data_pins_in,
   output logic [15:0] data_pins_out,
   output logic [15:0] data_pins_oe
);
   afp_ctl_if ctl ();
   afp_state_type state_reg, state_next;
   logic [15:0] addr_reg;
   logic [1:0] lanes_reg;
   logic write_reg;
   logic [15:0] wdata_reg;
   logic [15:0] sync1_reg, sync2_reg;
   logic [7:0] open_reg;
   logic accept, page_hit, col_end;
   logic ras_next, low_lane_col_strobe_n_next, high_lane_col_strobe_n_next, we_next, oe_next;
   logic [1:0] cas_lanes;
   logic [7:0] addr_next;
   logic [15:0] doe_next;
   logic [7:0] ras_low_cnt, ras_high_cnt;

   afp_timer u_timer (
      .clk(clk),
      .resetn(resetn),
      .t(ctl.timer)
   );

   afp_refresh u_refresh (
      .clk(clk),
      .resetn(resetn),
      .r(ctl.refresh)
   );

   // Memory data comes from outside the clock domain
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= data_pins_in;
         sync2_reg <= sync1_reg;
      end
   end

   // Same-row follow-up keeps the page open, bounded by longest row time
   assign page_hit = req_valid && !ctl.ref_due && (req_addr[15:8] == addr_reg[15:8]) &&
                     (open_reg < 8'(RAS_MAX_CYC - PAGE_GUARD_CYC));
   assign req_ready = (state_reg == S_IDLE && ctl.pwr_done && !ctl.ref_due) ||
                      (state_reg == S_PAGE && page_hit);
   assign accept = req_valid && req_ready;
   assign col_end = (state_reg == S_COL) && ctl.tmr_zero;
   // Unselected lanes mean a full word
   assign cas_lanes = (req_lanes == 2'h0) ? 2'h3 : req_lanes;

   // Sequencer
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         S_PWR: begin
            if (ctl.pwr_done) begin
               state_next = S_IDLE;
            end
         end
         S_IDLE: begin
            if (ctl.ref_due) begin
               state_next = S_CBRC;
            end else if (accept) begin
               state_next = S_ROW;
            end
         end
         S_ROW: state_next = S_COL;
         S_COL: begin
            if (ctl.tmr_zero) begin
               state_next = S_DONE;
            end
         end
         S_DONE: begin
            if (ctl.ref_due) begin
               state_next = S_HIDH;
            end else if (req_valid) begin
               state_next = S_PAGE;
            end else begin
               state_next = S_PRE;
            end
         end
         S_PAGE: begin
            if (page_hit) begin
               state_next = S_COL;
            end else begin
               state_next = S_PRE;
            end
         end
         S_HIDH: state_next = S_HIDL;
         S_HIDL, S_CBRR: begin
            if (ctl.tmr_zero) begin
               state_next = S_PRE;
            end
         end
         S_CBRC: state_next = S_CBRR;
         S_PRE: begin
            if (ctl.tmr_zero) begin
               state_next = S_IDLE;
            end
         end
         default: state_next = S_PWR;
      endcase
   end

   // Arm the timer on entry to each timed state
   always_comb begin
      ctl.tmr_load = 1'b0;
      ctl.tmr_val = '0;
      if (state_next != state_reg || state_reg == S_PAGE) begin
         unique case (state_next)
            S_COL: begin
               ctl.tmr_load = 1'b1;
               ctl.tmr_val = (state_reg == S_PAGE ? req_write : write_reg) ? '0 :
                             TMR_W'(RD_HOLD_CYC);
            end
            S_HIDL, S_CBRR: begin
               ctl.tmr_load = 1'b1;
               ctl.tmr_val = TMR_W'(RAS_MIN_CYC - 1);
            end
            S_PRE: begin
               ctl.tmr_load = 1'b1;
               ctl.tmr_val = TMR_W'(RP_CYC - 1);
            end
            default: ctl.tmr_load = 1'b0;
         endcase
      end
   end

   // A counter refresh is finished when its row strobe rises again
   assign ctl.ref_ack = (state_reg == S_CBRR || state_reg == S_HIDL) && state_next == S_PRE;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_reg <= S_PWR;
      end else begin
         state_reg <= state_next;
      end
   end

   // Request capture
   always_ff @(posedge clk) begin
      if (!resetn) begin
         addr_reg <= '0;
         lanes_reg <= '0;
         write_reg <= 1'b0;
         wdata_reg <= '0;
      end else if (accept) begin
         addr_reg <= req_addr;
         lanes_reg <= cas_lanes;
         write_reg <= req_write;
         wdata_reg <= req_wdata;
      end
   end

   // Row open time, for the longest row strobe
   always_ff @(posedge clk) begin
      if (!resetn || state_next == S_ROW) begin
         open_reg <= '0;
      end else if (!row_strobe_n && open_reg != 8'hff) begin
         open_reg <= open_reg + 1'b1;
      end
   end

   // Pin levels decoded from the next state, then registered glitch-free
   always_comb begin
      ras_next = !(state_next == S_ROW || state_next == S_COL || state_next == S_DONE ||
                   state_next == S_PAGE || state_next == S_HIDL || state_next == S_CBRR);
      low_lane_col_strobe_n_next = 1'b1;
      high_lane_col_strobe_n_next = 1'b1;
      we_next = 1'b1;
      oe_next = 1'b1;
      addr_next = addr_reg[15:8];
      doe_next = '0;
      if (state_next == S_CBRC || state_next == S_CBRR) begin
         low_lane_col_strobe_n_next = 1'b0;
         high_lane_col_strobe_n_next = 1'b0;
      end else if (state_next == S_COL || state_next == S_DONE ||
                   state_next == S_HIDH || state_next == S_HIDL) begin
         low_lane_col_strobe_n_next = (state_reg == S_PAGE) ? !cas_lanes[0] : !lanes_reg[0];
         high_lane_col_strobe_n_next = (state_reg == S_PAGE) ? !cas_lanes[1] : !lanes_reg[1];
         addr_next = (state_reg == S_PAGE) ? req_addr[7:0] : addr_reg[7:0];
         if ((state_reg == S_PAGE) ? req_write : write_reg) begin
            if (state_next == S_COL || state_next == S_DONE) begin
               we_next = 1'b0;
               doe_next = {{8{!high_lane_col_strobe_n_next}}, {8{!low_lane_col_strobe_n_next}}};
            end
         end else begin
            oe_next = 1'b0;
         end
      end
      // Row half comes from the request being taken, addr_reg is only loaded on this same edge
      if (state_next == S_ROW) begin
         addr_next = req_addr[15:8];
      end else if (state_next == S_PAGE) begin
         addr_next = addr_reg[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         row_strobe_n <= 1'b1;
         low_lane_col_strobe_n <= 1'b1;
         high_lane_col_strobe_n <= 1'b1;
         write_sel_n <= 1'b1;
         out_drive_n <= 1'b1;
         mux_addr_pins <= '0;
         data_pins_oe <= '0;
         data_pins_out <= '0;
      end else begin
         row_strobe_n <= ras_next;
         low_lane_col_strobe_n <= low_lane_col_strobe_n_next;
         high_lane_col_strobe_n <= high_lane_col_strobe_n_next;
         write_sel_n <= we_next;
         out_drive_n <= oe_next;
         mux_addr_pins <= addr_next;
         data_pins_oe <= doe_next;
         data_pins_out <= (state_reg == S_PAGE && accept) ? req_wdata : wdata_reg;
      end
   end

   // Read data taken once the synchronised lanes have settled
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= col_end;
         if (col_end && !write_reg) begin
            rsp_rdata <= sync2_reg;
         end
      end
   end

   // Helper counts of row strobe low and high time
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ras_low_cnt <= '0;
         ras_high_cnt <= '0;
      end else if (row_strobe_n) begin
         ras_low_cnt <= '0;
         ras_high_cnt <= (ras_high_cnt == 8'hff) ? ras_high_cnt : ras_high_cnt + 1'b1;
      end else begin
         ras_high_cnt <= '0;
         ras_low_cnt <= (ras_low_cnt == 8'hff) ? ras_low_cnt : ras_low_cnt + 1'b1;
      end
   end

   property p_row_half;
      @(posedge clk) disable iff (!resetn)
         ($fell(row_strobe_n) && low_lane_col_strobe_n && high_lane_col_strobe_n) |->
            mux_addr_pins == addr_reg[15:8];
   endproperty
   a_row_half: assert property (p_row_half) else $error("row half missing at row fall");

   property p_ras_min;
      @(posedge clk) disable iff (!resetn)
         $rose(row_strobe_n) |-> ras_low_cnt >= 8'(RAS_MIN_CYC);
   endproperty
   a_ras_min: assert property (p_ras_min) else $error("row strobe pulse too short");

   property p_ras_max;
      @(posedge clk) disable iff (!resetn) ras_low_cnt <= 8'(RAS_MAX_CYC);
   endproperty
   a_ras_max: assert property (p_ras_max) else $error("row strobe held too long");

   property p_precharge;
      @(posedge clk) disable iff (!resetn)
         $fell(row_strobe_n) |-> ras_high_cnt >= 8'(RP_CYC);
   endproperty
   a_precharge: assert property (p_precharge) else $error("precharge too short");

   property p_read_sel;
      @(posedge clk) disable iff (!resetn)
         !out_drive_n |-> write_sel_n && (data_pins_oe == '0) &&
            !(low_lane_col_strobe_n && high_lane_col_strobe_n);
   endproperty
   a_read_sel: assert property (p_read_sel) else $error("read with write select low");

   property p_col_stable;
      @(posedge clk) disable iff (!resetn)
         (!row_strobe_n && !out_drive_n && !$past(out_drive_n) && !$fell(low_lane_col_strobe_n) &&
            !$fell(high_lane_col_strobe_n)) |-> $stable(mux_addr_pins);
   endproperty
   a_col_stable: assert property (p_col_stable) else $error("column address moved in read");

   property p_write_data;
      @(posedge clk) disable iff (!resetn)
         $fell(write_sel_n) |-> (data_pins_oe[7:0] == {8{!low_lane_col_strobe_n}}) &&
            (data_pins_oe[15:8] == {8{!high_lane_col_strobe_n}}) ##1 !write_sel_n ##1 write_sel_n;
   endproperty
   a_write_data: assert property (p_write_data) else $error("write data lanes wrong");

   property p_cbr;
      @(posedge clk) disable iff (!resetn)
         ($fell(row_strobe_n) && (!$past(low_lane_col_strobe_n) || !$past(high_lane_col_strobe_n))) |->
            (data_pins_oe == '0) && write_sel_n;
   endproperty
   a_cbr: assert property (p_cbr) else $error("counter refresh drives data");

   property p_power_quiet;
      @(posedge clk) disable iff (!resetn)
         !ctl.pwr_done |-> row_strobe_n && low_lane_col_strobe_n && high_lane_col_strobe_n;
   endproperty
   a_power_quiet: assert property (p_power_quiet) else $error("strobes during power pause");

   property p_page_ras;
      @(posedge clk) disable iff (!resetn)
         (state_reg == S_PAGE && page_hit) |=> !row_strobe_n ##1 !row_strobe_n;
   endproperty
   a_page_ras: assert property (p_page_ras) else $error("row dropped in page access");

   c_read: cover property (@(posedge clk) disable iff (!resetn) rsp_valid && !write_reg);
   c_write: cover property (@(posedge clk) disable iff (!resetn) $fell(write_sel_n));
   c_page: cover property (@(posedge clk) disable iff (!resetn) state_reg == S_PAGE && page_hit);
   c_hidden: cover property (@(posedge clk) disable iff (!resetn) state_reg == S_HIDL);
   c_cbr: cover property (@(posedge clk) disable iff (!resetn) state_reg == S_CBRR);
endmodule
`default_nettype wire

// ==== dv/afp_dram_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module afp_dram_model (
   input wire logic row_strobe_n,
   input wire logic low_lane_col_strobe_n,
   input wire logic high_lane_col_strobe_n,
   input wire logic write_sel_n,
   input wire logic out_drive_n,
   input wire logic [7:0] mux_addr_pins,
   input wire logic [15:0] data_pins_out,
   output logic [15:0] data_pins_in,
   output int ref_count
);
   logic [15:0] mem [0:65535];
   logic [7:0] row_reg;
   logic [7:0] col_reg;
   logic [7:0] ref_row_reg;
   logic cbr_reg;
   logic acc_reg;
   logic [15:0] last_reg;
   logic [15:0] drv;
   wire logic cas_n = low_lane_col_strobe_n & high_lane_col_strobe_n;
   wire logic [15:0] dout = mem[{row_reg, col_reg}];
   initial begin
      ref_count = 0;
      cbr_reg = 1'b0;
      acc_reg = 1'b0;
      row_reg = 8'h00;
      col_reg = 8'h00;
      ref_row_reg = 8'h00;
      last_reg = 16'h0000;
   end
   // Row fall: counter refresh when a column strobe is already low
   always @(negedge row_strobe_n) begin
      #1;
      if (!cas_n) begin
         cbr_reg = 1'b1;
         ref_row_reg = ref_row_reg + 8'h01;
         ref_count = ref_count + 1;
      end else begin
         cbr_reg = 1'b0;
         row_reg = mux_addr_pins;
      end
   end
   // Column fall opens an access only inside a row cycle
   always @(negedge cas_n) begin
      #1;
      acc_reg = !row_strobe_n && !cbr_reg;
      col_reg = mux_addr_pins;
   end
   always @(posedge cas_n) acc_reg = 1'b0;
   // Late of the two falls writes; data sampled just after it
   always @(negedge cas_n or negedge write_sel_n) begin
      #2;
      if (acc_reg && !write_sel_n) begin
         if (!low_lane_col_strobe_n) mem[{row_reg, col_reg}][7:0] = data_pins_out[7:0];
         if (!high_lane_col_strobe_n) mem[{row_reg, col_reg}][15:8] = data_pins_out[15:8];
      end
   end
   // Hidden refresh keeps acc_reg, so read data stays driven
   assign drv[7:0] = {8{acc_reg && !low_lane_col_strobe_n && !out_drive_n && write_sel_n}};
   assign drv[15:8] = {8{acc_reg && !high_lane_col_strobe_n && !out_drive_n && write_sel_n}};
   assign data_pins_in = (drv & dout) | (~drv & ~last_reg);
   // Released bits toggle, so a stale capture never looks right
   always #10 last_reg = data_pins_in;
endmodule
`default_nettype wire

// ==== dv/tb_async_fast_page_dram_port.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_async_fast_page_dram_port;
   import afp_pkg::*;
   logic clk, resetn, req_valid, req_ready, req_write, rsp_valid;
   logic [15:0] req_addr, req_wdata, rsp_rdata, data_pins_in, data_pins_out, data_pins_oe;
   logic [1:0] req_lanes;
   logic row_strobe_n, low_lane_col_strobe_n, high_lane_col_strobe_n, write_sel_n, out_drive_n;
   logic [7:0] mux_addr_pins;
   logic [15:0] gmem [0:65535];
   bit [15:0] gknown [0:65535];
   int ref_count, err_count, checked, seed, cyc, lo_cnt, hi_cnt, col_cnt, start, r0, r;
   logic prev_row, prev_cas;
   logic pend, pw;
   logic [15:0] pa, pd;
   logic [1:0] pl;
   wire logic cas_n = low_lane_col_strobe_n & high_lane_col_strobe_n;
   afp_dram_ctrl afp_dram_ctrl_i (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_addr(req_addr), .req_lanes(req_lanes), .req_wdata(req_wdata),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .row_strobe_n(row_strobe_n),
      .low_lane_col_strobe_n(low_lane_col_strobe_n), .high_lane_col_strobe_n(high_lane_col_strobe_n),
      .write_sel_n(write_sel_n), .out_drive_n(out_drive_n), .mux_addr_pins(mux_addr_pins),
      .data_pins_in(data_pins_in), .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe));
   afp_dram_model afp_dram_model_i (.row_strobe_n(row_strobe_n), .low_lane_col_strobe_n(low_lane_col_strobe_n),
      .high_lane_col_strobe_n(high_lane_col_strobe_n), .write_sel_n(write_sel_n), .out_drive_n(out_drive_n),
      .mux_addr_pins(mux_addr_pins), .data_pins_out(data_pins_out), .data_pins_in(data_pins_in),
      .ref_count(ref_count));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   task automatic test_done();
      $display("mismatches %0d comparisons %0d", err_count, checked);
      if (err_count == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check16(input string name, input logic [15:0] exp, input logic [15:0] got, input logic [15:0] m);
      checked++;
      if ((got & m) !== (exp & m)) begin
         $display("unexpected %s expected %h seen %h", name, exp & m, got & m);
         err_count++;
      end
   endtask
   task automatic check_flag(input string name, input logic got);
      checked++;
      if (got !== 1'b1) begin
         $display("unexpected %s expected 1 seen %b", name, got);
         err_count++;
      end
   endtask
   // Lane code 00 means the whole word
   function automatic logic [15:0] lane_mask(input logic [1:0] l);
      return (l == 2'b00) ? 16'hffff : {{8{l[1]}}, {8{l[0]}}};
   endfunction
   // Answer of the outstanding request, taken in the cycle it shows
   task automatic take_rsp();
      pend = 1'b0;
      if (pw) begin
         gmem[pa] = (gmem[pa] & ~lane_mask(pl)) | (pd & lane_mask(pl));
         gknown[pa] = gknown[pa] | lane_mask(pl);
      end else begin
         check16("read data", gmem[pa], rsp_rdata, lane_mask(pl) & gknown[pa]);
      end
   endtask
   // One request, held until taken; returns at once so the next one can reach page mode
   task automatic do_req(input logic w, input logic [15:0] a, input logic [1:0] l, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_lanes <= l;
      req_wdata <= d;
      do begin
         @(posedge clk);
         n++;
         if (pend && rsp_valid === 1'b1) take_rsp();
      end while (req_ready !== 1'b1 && n < 3000);
      req_valid <= 1'b0;
      if (req_ready !== 1'b1 || pend) begin
         err_count++;
         test_done();
      end
      pend = 1'b1;
      pw = w;
      pa = a;
      pl = l;
      pd = d;
   endtask
   // Bounded wait for the last answer
   task automatic drain();
      int n;
      n = 0;
      while (pend && n < 100) begin
         @(posedge clk);
         n++;
         if (rsp_valid === 1'b1) take_rsp();
      end
      if (pend) begin
         err_count++;
         test_done();
      end
   endtask
   // Waits out power-up, counting pause and wake-up row cycles
   task automatic wait_ready();
      int n;
      int falls;
      logic prev;
      n = 0;
      falls = 0;
      prev = 1'b1;
      while (req_ready !== 1'b1 && n < 4000) begin
         @(posedge clk);
         n++;
         if (prev && !row_strobe_n) begin
            falls++;
            if (falls == 1) check_flag("power pause", n >= PWR_CYC);
         end
         prev = row_strobe_n;
      end
      check_flag("wake cycles", falls >= WAKE_CYCLES);
      if (n >= 4000) begin
         err_count++;
         test_done();
      end
   endtask
   // Pin watch: strobe widths, page length, data drive per cycle kind
   always @(posedge clk) begin
      if (!resetn) begin
         lo_cnt = 0;
         hi_cnt = 0;
         col_cnt = 0;
         prev_row = 1'b1;
         prev_cas = 1'b1;
      end else begin
         if (prev_row && !row_strobe_n) begin
            check_flag("precharge", hi_cnt >= RP_CYC);
            if (!cas_n) check16("refresh drive", 16'h0000, data_pins_oe, 16'hffff);
            lo_cnt = 0;
            col_cnt = 0;
         end
         if (!prev_row && row_strobe_n) begin
            check_flag("row width", lo_cnt >= RAS_MIN_CYC && lo_cnt <= RAS_MAX_CYC);
            hi_cnt = 0;
         end
         if (prev_cas && !cas_n && !row_strobe_n) begin
            col_cnt++;
            check_flag("page length", col_cnt <= 256);
         end
         if (!cas_n && !write_sel_n) begin
            check16("write drive", {{8{!high_lane_col_strobe_n}}, {8{!low_lane_col_strobe_n}}}, data_pins_oe,
                    16'hffff);
         end
         if (!cas_n && !out_drive_n) check_flag("read select", write_sel_n && data_pins_oe == 16'h0000);
         if (row_strobe_n) hi_cnt++;
         else lo_cnt++;
         prev_row = row_strobe_n;
         prev_cas = cas_n;
      end
   end
   initial begin
      resetn = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 16'h0000;
      req_lanes = 2'b00;
      req_wdata = 16'h0000;
      seed = 2507;
      err_count = 0;
      checked = 0;
      pend = 1'b0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      wait_ready();
      // Every lane code written then read back with a different one
      do_req(1'b1, 16'h1200, 2'b11, 16'h1234);
      for (int l = 0; l < 4; l++) begin
         do_req(1'b1, 16'h1200, 2'(l), 16'ha5c3 ^ 16'(l * 16'h1111));
         do_req(1'b0, 16'h1200, 2'(3 - l), 16'h0000);
      end
      // Page neighbours, last column, then a row change
      do_req(1'b1, 16'h12ff, 2'b11, 16'hbeef);
      do_req(1'b0, 16'h12ff, 2'b11, 16'h0000);
      do_req(1'b0, 16'h1200, 2'b01, 16'h0000);
      do_req(1'b0, 16'h3412, 2'b11, 16'h0000);
      // Random traffic over one refresh period, on few rows for page hits
      start = cyc;
      r0 = ref_count;
      while (cyc - start < 40000) begin
         r = $random(seed);
         do_req(r[16], {6'h0a, r[9:0]}, r[18:17], 16'($random(seed)));
      end
      drain();
      check_flag("refresh count", ref_count - r0 >= REF_ROWS);
      // Reset mid-run: pins idle, wake-up again, memory kept
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      check_flag("reset pins", row_strobe_n && !cas_n == 1'b0 && data_pins_oe == 16'h0000 && !rsp_valid);
      resetn <= 1'b1;
      wait_ready();
      do_req(1'b1, 16'hffff, 2'b10, 16'hc3c3);
      do_req(1'b0, 16'hffff, 2'b00, 16'h0000);
      do_req(1'b0, 16'h12ff, 2'b11, 16'h0000);
      drain();
      test_done();
   end
endmodule
`default_nettype wire
